/* core/flash_cmd_dev.sv */
// Purpose: Device end: decodes suspend, resume, OTP and protection commands
// Assumes: Link pins are synchronous to i_clk_sys and the serial clock
//          half period is at least three system cycles
// Notes:   Data sampled on serial clock rise, driven after serial clock fall
module flash_cmd_dev #(
   parameter int SECT_W = flash_cmd_pkg::SECT_W,
   parameter int SECT_SHIFT = flash_cmd_pkg::SECT_SHIFT
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // Configuration
   input wire logic i_addr4,
   // Link
   flash_link_if.dev link,
   // Operation control toward the array core
   output logic o_suspend_req,
   output logic o_suspend_all,
   output logic o_resume_req,
   // Protection state
   output logic o_write_enabled,
   output logic [15:0] o_protect_config,
   output logic [(1<<SECT_W)-1:0] o_sector_locks
);

   // ==========================================================
   // Serial edge detection
   logic sck_q;
   logic cs_q;
   logic rise;
   logic fall;
   logic cs_rise;

   // Link inputs are already synchronous, so one stage gives edges
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sck_q <= 1'b0;
         cs_q <= 1'b1;
      end else begin
         sck_q <= link.sck;
         cs_q <= link.cs_n;
      end
   end

   assign rise = !link.cs_n && !sck_q && link.sck;
   assign fall = !link.cs_n && sck_q && !link.sck;
   assign cs_rise = !cs_q && link.cs_n;

   // ==========================================================
   // Byte assembly and phase tracking
   flash_cmd_pkg::phase_t phase;
   logic [2:0] bit_cnt;
   logic [6:0] rx;
   logic [7:0] byte_in;
   logic byte_done;
   logic [7:0] opcode;
   logic [2:0] acnt;
   logic [31:0] addr;
   logic [31:0] next_addr;
   logic data_idx;
   logic [7:0] cfg_lo;
   logic one_byte;
   logic [7:0] tx;
   logic [7:0] otp [flash_cmd_pkg::OTP_BYTES];
   logic [SECT_W-1:0] sect_new;
   logic [SECT_W-1:0] sect_cur;

   assign byte_in = {rx, link.mosi};
   assign byte_done = rise && (bit_cnt == flash_cmd_pkg::BIT_LAST);
   assign next_addr = {addr[23:0], byte_in};
   assign sect_new = next_addr[SECT_SHIFT +: SECT_W];
   assign sect_cur = addr[SECT_SHIFT +: SECT_W];

   // Bit count restarts whenever select is high
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bit_cnt <= 3'h0;
         rx <= 7'h00;
      end else if (link.cs_n) begin
         bit_cnt <= 3'h0;
      end else if (rise) begin
         bit_cnt <= bit_cnt + 3'h1;
         rx <= byte_in[6:0];
      end
   end

   // Opcode decode picks the address length of each command
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         phase <= flash_cmd_pkg::PH_OPCODE;
         opcode <= 8'h00;
         acnt <= flash_cmd_pkg::ALEN_NONE;
         data_idx <= 1'b0;
      end else if (link.cs_n) begin
         phase <= flash_cmd_pkg::PH_OPCODE;
         data_idx <= 1'b0;
      end else if (byte_done) begin
         unique case (phase)
            flash_cmd_pkg::PH_OPCODE: begin
               opcode <= byte_in;
               phase <= flash_cmd_pkg::PH_ADDR;
               case (byte_in)
                  flash_cmd_pkg::otp_program_cmd,
                  flash_cmd_pkg::otp_read_cmd: begin
                     acnt <= i_addr4 ? flash_cmd_pkg::ALEN_WIDE : flash_cmd_pkg::ALEN_SHORT;
                  end
                  flash_cmd_pkg::volatile_lock_read_cmd,
                  flash_cmd_pkg::volatile_lock_write_cmd: begin
                     acnt <= flash_cmd_pkg::ALEN_SHORT;
                  end
                  flash_cmd_pkg::volatile_lock_read_wide_cmd,
                  flash_cmd_pkg::volatile_lock_write_wide_cmd: begin
                     acnt <= flash_cmd_pkg::ALEN_WIDE;
                  end
                  flash_cmd_pkg::protect_config_write_cmd: begin
                     phase <= flash_cmd_pkg::PH_DATA;
                  end
                  default: begin
                     phase <= flash_cmd_pkg::PH_REST;
                  end
               endcase
            end
            flash_cmd_pkg::PH_ADDR: begin
               acnt <= acnt - 3'h1;
               if (acnt == 3'h1) begin
                  phase <= flash_cmd_pkg::PH_DATA;
               end
            end
            flash_cmd_pkg::PH_DATA: begin
               data_idx <= 1'b1;
               // Lock and config writes take a fixed count, extra bytes ignored
               if (opcode != flash_cmd_pkg::otp_program_cmd &&
                   opcode != flash_cmd_pkg::otp_read_cmd &&
                   (data_idx || opcode != flash_cmd_pkg::protect_config_write_cmd)) begin
                  phase <= flash_cmd_pkg::PH_REST;
               end
            end
            flash_cmd_pkg::PH_REST: begin
               phase <= flash_cmd_pkg::PH_REST;
            end
         endcase
      end
   end

   // ==========================================================
   // Address: MSB first, then steps through OTP bytes
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         addr <= 32'h0;
      end else if (link.cs_n) begin
         addr <= 32'h0;
      end else if (byte_done) begin
         if (phase == flash_cmd_pkg::PH_ADDR) begin
            // Read pre-fetches, so the pointer runs one byte ahead
            if (acnt == 3'h1 && opcode == flash_cmd_pkg::otp_read_cmd) begin
               addr <= next_addr + 32'h1;
            end else begin
               addr <= next_addr;
            end
         end else if (phase == flash_cmd_pkg::PH_DATA && (opcode == flash_cmd_pkg::otp_read_cmd ||
                      opcode == flash_cmd_pkg::otp_program_cmd)) begin
            addr <= addr + 32'h1;
         end
      end
   end

   // ==========================================================
   // Read data: loaded at a byte boundary, bits driven after each fall
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx <= 8'h00;
      end else if (link.cs_n) begin
         tx <= 8'h00;
      end else if (byte_done) begin
         if (phase == flash_cmd_pkg::PH_ADDR && acnt == 3'h1) begin
            if (opcode == flash_cmd_pkg::otp_read_cmd) begin
               tx <= otp[next_addr[flash_cmd_pkg::OTP_AW-1:0]];
            end else if (opcode == flash_cmd_pkg::volatile_lock_read_cmd ||
                         opcode == flash_cmd_pkg::volatile_lock_read_wide_cmd) begin
               // Lock byte repeats while the host clocks
               tx <= o_sector_locks[sect_new] ? flash_cmd_pkg::BYTE_LOCKED :
                     flash_cmd_pkg::BYTE_UNLOCKED;
            end
         end else if (phase == flash_cmd_pkg::PH_DATA && opcode == flash_cmd_pkg::otp_read_cmd) begin
            tx <= otp[addr[flash_cmd_pkg::OTP_AW-1:0]];
         end
      end
   end

   // Bit index is the inverse of the count, MSB first
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         link.miso <= 1'b0;
      end else if (fall) begin
         link.miso <= tx[~bit_cnt];
      end
   end

   // ==========================================================
   // OTP array: programming only clears bits
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int i = 0; i < flash_cmd_pkg::OTP_BYTES; i++) begin
            otp[i] <= flash_cmd_pkg::BYTE_ERASED;
         end
      end else if (byte_done && phase == flash_cmd_pkg::PH_DATA &&
                   opcode == flash_cmd_pkg::otp_program_cmd && o_write_enabled) begin
         otp[addr[flash_cmd_pkg::OTP_AW-1:0]] <=
            otp[addr[flash_cmd_pkg::OTP_AW-1:0]] & byte_in;
      end
   end

   // Sector locks: all-ones byte locks, else unlocks
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_sector_locks <= '0;
      end else if (byte_done && phase == flash_cmd_pkg::PH_DATA && o_write_enabled &&
                   (opcode == flash_cmd_pkg::volatile_lock_write_cmd ||
                    opcode == flash_cmd_pkg::volatile_lock_write_wide_cmd)) begin
         o_sector_locks[sect_cur] <= (byte_in == flash_cmd_pkg::BYTE_LOCKED);
      end
   end

   // Configuration word commits only once the high byte arrives
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg_lo <= 8'h00;
         o_protect_config <= flash_cmd_pkg::PROTECT_CONFIG_RESET;
      end else if (byte_done && phase == flash_cmd_pkg::PH_DATA &&
                   opcode == flash_cmd_pkg::protect_config_write_cmd) begin
         if (!data_idx) begin
            cfg_lo <= byte_in;
         end else if (o_write_enabled) begin
            o_protect_config <= {byte_in, cfg_lo};
         end
      end
   end

   // ==========================================================
   // Single byte commands act when select rises after exactly one byte
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         one_byte <= 1'b0;
      end else if (link.cs_n) begin
         one_byte <= 1'b0;
      end else if (rise) begin
         one_byte <= byte_done && phase == flash_cmd_pkg::PH_OPCODE;
      end
   end

   // Write enable latch, cleared at the end of any write frame
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_write_enabled <= 1'b0;
      end else if (cs_rise) begin
         if (one_byte && opcode == flash_cmd_pkg::write_enable_cmd) begin
            o_write_enabled <= 1'b1;
         end else if (opcode == flash_cmd_pkg::otp_program_cmd ||
                      opcode == flash_cmd_pkg::volatile_lock_write_cmd ||
                      opcode == flash_cmd_pkg::volatile_lock_write_wide_cmd ||
                      opcode == flash_cmd_pkg::protect_config_write_cmd) begin
            o_write_enabled <= 1'b0;
         end
      end
   end

   // Suspend and resume pulses; any trailing bit cancels them
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_suspend_req <= 1'b0;
         o_suspend_all <= 1'b0;
         o_resume_req <= 1'b0;
      end else begin
         o_suspend_req <= 1'b0;
         o_resume_req <= 1'b0;
         if (cs_rise && one_byte) begin
            case (opcode)
               flash_cmd_pkg::suspend_all_ops_cmd: begin
                  o_suspend_req <= 1'b1;
                  o_suspend_all <= 1'b1;
               end
               flash_cmd_pkg::suspend_alt_cmd,
               flash_cmd_pkg::suspend_alt2_cmd: begin
                  o_suspend_req <= 1'b1;
                  o_suspend_all <= 1'b0;
               end
               flash_cmd_pkg::resume_all_ops_cmd,
               flash_cmd_pkg::resume_alt_cmd,
               flash_cmd_pkg::resume_alt2_cmd: begin
                  o_resume_req <= 1'b1;
               end
            endcase
         end
      end
   end

endmodule

/* core/flash_cmd_pkg.sv */
// Purpose: Shared constants for the serial flash command ends
// Assumes: Single lane, mode 0 framing, one byte opcode first
// Notes:   Opcodes, address lengths and fixed byte values live here
package flash_cmd_pkg;

   // ==========================================================
   // Opcodes
   localparam logic [7:0] write_enable_cmd = 8'h06;
   localparam logic [7:0] suspend_all_ops_cmd = 8'h75;
   localparam logic [7:0] suspend_alt_cmd = 8'h85;
   localparam logic [7:0] suspend_alt2_cmd = 8'hb0;
   localparam logic [7:0] resume_all_ops_cmd = 8'h7a;
   localparam logic [7:0] resume_alt_cmd = 8'h8a;
   localparam logic [7:0] resume_alt2_cmd = 8'h30;
   localparam logic [7:0] otp_program_cmd = 8'h42;
   localparam logic [7:0] otp_read_cmd = 8'h4b;
   localparam logic [7:0] protect_config_write_cmd = 8'h2f;
   localparam logic [7:0] volatile_lock_read_cmd = 8'hfa;
   localparam logic [7:0] volatile_lock_read_wide_cmd = 8'he0;
   localparam logic [7:0] volatile_lock_write_cmd = 8'hfb;
   localparam logic [7:0] volatile_lock_write_wide_cmd = 8'he1;

   // ==========================================================
   // Sizes and fixed values
   localparam int OTP_BYTES = 1024;
   localparam int OTP_AW = 10;
   localparam logic [2:0] ALEN_NONE = 3'h0;
   localparam logic [2:0] ALEN_SHORT = 3'h3;
   localparam logic [2:0] ALEN_WIDE = 3'h4;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [7:0] BYTE_ERASED = 8'hff;
   localparam logic [7:0] BYTE_LOCKED = 8'hff;
   localparam logic [7:0] BYTE_UNLOCKED = 8'h00;
   localparam logic [15:0] PROTECT_CONFIG_RESET = 16'hffff;
   localparam int SECT_SHIFT = 18;
   localparam int SECT_W = 8;
   localparam int SCK_HALF = 4;

   // Device-side decode phase
   typedef enum logic [1:0] {
      PH_OPCODE,
      PH_ADDR,
      PH_DATA,
      PH_REST
   } phase_t;

   // Host-side sequencer
   typedef enum logic [1:0] {
      H_IDLE,
      H_RUN,
      H_END
   } host_state_t;

endpackage

/* core/flash_link_if.sv */
// Purpose: Serial link between host controller and flash command end
// Assumes: Host drives clock, select and data out; device drives data back
// Notes:   No two-way pins on a single lane link
interface flash_link_if;
   logic sck;
   logic cs_n;
   logic mosi;
   logic miso;

   modport host (output sck, output cs_n, output mosi, input miso);
   modport dev (input sck, input cs_n, input mosi, output miso);
endinterface

/* core/flash_cmd_host.sv */
// Purpose: Host end: frames one command transaction on the serial link
// Assumes: User holds request fields stable from start until done
// Notes:   Serial clock is a divided copy of i_clk_sys, mode 0
module flash_cmd_host #(
   parameter int SCK_HALF = flash_cmd_pkg::SCK_HALF
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // Request
   input wire logic i_start,
   input wire logic [7:0] i_opcode,
   input wire logic [31:0] i_addr,
   input wire logic [2:0] i_alen,
   input wire logic [7:0] i_nbytes,
   input wire logic [7:0] i_wdata,
   // Answer
   output logic o_busy,
   output logic o_done,
   output logic o_wdata_take,
   output logic o_rvalid,
   output logic [7:0] o_rdata,
   // Link
   flash_link_if.host link
);

   // ==========================================================
   // Sequencer state
   flash_cmd_pkg::host_state_t state;
   logic [7:0] div;
   logic tick;
   logic [2:0] bit_cnt;
   logic [8:0] byte_idx;
   logic [8:0] last_idx;
   logic [7:0] tx;
   logic [6:0] rx;
   logic [2:0] sh;
   logic [31:0] shifted;
   logic [8:0] nxt_idx;
   logic [7:0] next_tx;
   logic nxt_is_data;

   assign tick = (div == 8'(SCK_HALF - 1));
   assign nxt_idx = byte_idx + 9'h1;
   assign nxt_is_data = nxt_idx > {6'h0, i_alen};
   assign sh = 3'(i_alen - nxt_idx[2:0]);
   assign shifted = i_addr >> {sh, 3'b000};

   // Address bytes go out most significant first, then user data
   assign next_tx = nxt_is_data ? i_wdata : shifted[7:0];

   // Half period divider, runs only while a frame is open
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div <= 8'h00;
      end else if (state == flash_cmd_pkg::H_IDLE || tick) begin
         div <= 8'h00;
      end else begin
         div <= div + 8'h01;
      end
   end

   // ==========================================================
   // Frame sequencer: sample on rise, shift on fall
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= flash_cmd_pkg::H_IDLE;
         link.sck <= 1'b0;
         link.cs_n <= 1'b1;
         link.mosi <= 1'b0;
         bit_cnt <= 3'h0;
         byte_idx <= 9'h0;
         last_idx <= 9'h0;
         tx <= 8'h00;
         rx <= 7'h00;
         o_busy <= 1'b0;
         o_done <= 1'b0;
         o_wdata_take <= 1'b0;
         o_rvalid <= 1'b0;
         o_rdata <= 8'h00;
      end else begin
         o_done <= 1'b0;
         o_wdata_take <= 1'b0;
         o_rvalid <= 1'b0;
         unique case (state)
            flash_cmd_pkg::H_IDLE: begin
               if (i_start) begin
                  state <= flash_cmd_pkg::H_RUN;
                  link.cs_n <= 1'b0;
                  tx <= i_opcode;
                  link.mosi <= i_opcode[7];
                  bit_cnt <= 3'h0;
                  byte_idx <= 9'h0;
                  last_idx <= 9'({6'h0, i_alen} + {1'b0, i_nbytes});
                  o_busy <= 1'b1;
               end
            end
            flash_cmd_pkg::H_RUN: begin
               if (tick && !link.sck) begin
                  link.sck <= 1'b1;
                  rx <= {rx[5:0], link.miso};
                  bit_cnt <= bit_cnt + 3'h1;
                  if (bit_cnt == flash_cmd_pkg::BIT_LAST && byte_idx > {6'h0, i_alen}) begin
                     o_rdata <= {rx, link.miso};
                     o_rvalid <= 1'b1;
                  end
               end else if (tick) begin
                  link.sck <= 1'b0;
                  if (bit_cnt != 3'h0) begin
                     link.mosi <= tx[~bit_cnt];
                  end else if (byte_idx == last_idx) begin
                     state <= flash_cmd_pkg::H_END;
                  end else begin
                     // User may present the next data byte after this
                     byte_idx <= nxt_idx;
                     tx <= next_tx;
                     link.mosi <= next_tx[7];
                     o_wdata_take <= nxt_is_data;
                  end
               end
            end
            flash_cmd_pkg::H_END: begin
               if (tick) begin
                  link.cs_n <= 1'b1;
                  state <= flash_cmd_pkg::H_IDLE;
                  o_busy <= 1'b0;
                  o_done <= 1'b1;
               end
            end
            default: begin
               state <= flash_cmd_pkg::H_IDLE;
            end
         endcase
      end
   end

endmodule

/* verif/flash_link_properties.sv */
// Purpose: Link checks between the host and device command ends
// Assumes: Mode 0 framing, one system clock domain, SCK_HALF of 4 or 5
// Notes:   Instantiated beside the link interface, watches the wire only
module flash_link_properties #(
   parameter int SCK_HALF = 4
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // Link
   input wire logic sck,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso
);
   // ====================
   // Helper counters
   logic [7:0] hi_len;
   logic [2:0] bit_cnt;
   logic sck_q;

   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);

   // Length of the current high phase; a counter avoids a long repetition
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         hi_len <= 8'h00;
      end else begin
         hi_len <= sck ? hi_len + 8'h01 : 8'h00;
      end
   end

   // Bits of the open frame modulo eight
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sck_q <= 1'b0;
         bit_cnt <= 3'h0;
      end else begin
         sck_q <= sck;
         if (cs_n) begin
            bit_cnt <= 3'h0;
         end else if (sck && !sck_q) begin
            bit_cnt <= bit_cnt + 3'h1;
         end
      end
   end

   // ====================
   // Properties
   property p_sck_idle;
      cs_n |-> !sck;
   endproperty
   a_sck_idle: assert property (p_sck_idle)
      else $error("sck high while deselected");

   property p_mosi_hold;
      sck && $past(sck) |-> $stable(mosi);
   endproperty
   a_mosi_hold: assert property (p_mosi_hold)
      else $error("mosi moved while sck high");

   property p_miso_hold;
      sck && $past(sck) |-> $stable(miso);
   endproperty
   a_miso_hold: assert property (p_miso_hold)
      else $error("miso moved while sck high");

   property p_sck_high;
      $fell(sck) |-> hi_len == 8'(SCK_HALF);
   endproperty
   a_sck_high: assert property (p_sck_high)
      else $error("sck high phase length");

   property p_sck_low;
      $fell(sck) |-> !sck[*4];
   endproperty
   a_sck_low: assert property (p_sck_low)
      else $error("sck low phase short");

   property p_frame_start;
      $fell(cs_n) |-> !sck[*3] ##[1:3] sck;
   endproperty
   a_frame_start: assert property (p_frame_start)
      else $error("first sck rise misplaced");

   // Every frame closes on a whole byte boundary
   property p_whole_bytes;
      $rose(cs_n) |-> bit_cnt == 3'h0;
   endproperty
   a_whole_bytes: assert property (p_whole_bytes)
      else $error("partial byte at frame end");

   property p_frame_end;
      $rose(cs_n) |-> !$past(sck) && !$past(sck, 2) && !$past(sck, 3);
   endproperty
   a_frame_end: assert property (p_frame_end)
      else $error("frame closed too soon");
endmodule

/* verif/tb_flash_suspend_otp_protect_cmds.sv */
// Purpose: Self-checking bench joining the host and device command ends
// Assumes: SCK_HALF of 4, system clock of 250 MHz
// Notes:   Expected values come from a bench-side OTP copy and the lock_byte helper
module tb_flash_suspend_otp_protect_cmds;
   timeunit 1ns;
   timeprecision 1ps;
   // ====================
   // Signals
   logic i_clk_sys, i_rst_n, i_addr4, i_start;
   logic [7:0] i_opcode, i_nbytes, i_wdata, o_rdata;
   logic [31:0] i_addr, a;
   logic [2:0] i_alen, al;
   logic o_busy, o_done, o_wdata_take, o_rvalid;
   logic o_suspend_req, o_suspend_all, o_resume_req, o_write_enabled;
   logic [15:0] o_protect_config;
   logic [255:0] o_sector_locks;
   logic [7:0] wd[8], rd[8], otp[1024], ops[6];
   int err_total, checked, n_susp, n_res, s0, r0, i, j, seed;

   flash_link_if link_if ();
   flash_cmd_host #(.SCK_HALF(4)) flash_cmd_host_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
      .i_start(i_start), .i_opcode(i_opcode), .i_addr(i_addr), .i_alen(i_alen),
      .i_nbytes(i_nbytes), .i_wdata(i_wdata), .o_busy(o_busy), .o_done(o_done),
      .o_wdata_take(o_wdata_take), .o_rvalid(o_rvalid), .o_rdata(o_rdata), .link(link_if));
   flash_cmd_dev flash_cmd_dev_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr4(i_addr4),
      .link(link_if), .o_suspend_req(o_suspend_req), .o_suspend_all(o_suspend_all),
      .o_resume_req(o_resume_req), .o_write_enabled(o_write_enabled),
      .o_protect_config(o_protect_config), .o_sector_locks(o_sector_locks));
   flash_link_properties #(.SCK_HALF(4)) flash_link_properties_i (.i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n), .sck(link_if.sck), .cs_n(link_if.cs_n), .mosi(link_if.mosi),
      .miso(link_if.miso));

   // ====================
   // Clock, pulse counters and watchdog
   initial begin
      i_clk_sys = 1'b0;
      forever #2 i_clk_sys = ~i_clk_sys;
   end

   // Counted at the falling edge so one-cycle pulses are settled
   always @(negedge i_clk_sys) begin
      if (o_suspend_req === 1'b1) n_susp++;
      if (o_resume_req === 1'b1) n_res++;
   end

   // About 31 frames of at most 600 cycles; four times that cuts a hang
   initial begin
      #300000;
      err_total++;
      finish_test();
   end

   // ====================
   // Helpers
   function automatic logic [7:0] lock_byte(input logic locked);
      return locked ? flash_cmd_pkg::BYTE_LOCKED : flash_cmd_pkg::BYTE_UNLOCKED;
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask

   task automatic finish_test();
      $display("checks=%0d errors=%0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // One frame; next data byte offered a cycle after the take
   task automatic run(input logic [7:0] op, input logic [31:0] ad, input logic [2:0] alen,
      input logic [7:0] n);
      int k, w, r;
      bit pend;
      w = 0;
      r = 0;
      pend = 0;
      i_opcode = op;
      i_addr = ad;
      i_alen = alen;
      i_nbytes = n;
      i_wdata = wd[0];
      i_start = 1'b1;
      @(negedge i_clk_sys);
      i_start = 1'b0;
      for (k = 0; k < 3000 && o_done !== 1'b1; k++) begin
         @(negedge i_clk_sys);
         if (o_rvalid === 1'b1 && r < 8) begin
            rd[r] = o_rdata;
            r++;
         end
         if (o_wdata_take === 1'b1) begin
            pend = 1;
         end else if (pend) begin
            pend = 0;
            w++;
            i_wdata = wd[w % 8];
         end
      end
      chk({15'h0, o_done}, 16'h1);
      chk({15'h0, o_busy}, 16'h0);
      // Device wants the select high for two cycles; late pulses land here too
      repeat (6) @(negedge i_clk_sys);
   endtask

   task automatic rd_otp(input logic [2:0] alen);
      logic [9:0] ax;
      ax = a[9:0];
      run(flash_cmd_pkg::otp_read_cmd, a, alen, 8'h03);
      for (int k = 0; k < 3; k++) begin
         chk({8'h00, rd[k]}, {8'h00, otp[ax]});
         ax = ax + 10'h001;
      end
   endtask

   // ====================
   // Main sequence
   initial begin
      seed = 32'h57117588;
      i_rst_n = 1'b0;
      i_start = 1'b0;
      i_addr4 = 1'b0;
      i_opcode = 8'h00;
      i_addr = 32'h0;
      i_alen = 3'h0;
      i_nbytes = 8'h00;
      i_wdata = 8'h00;
      ops = '{flash_cmd_pkg::suspend_all_ops_cmd, flash_cmd_pkg::suspend_alt_cmd,
         flash_cmd_pkg::suspend_alt2_cmd, flash_cmd_pkg::resume_all_ops_cmd,
         flash_cmd_pkg::resume_alt_cmd, flash_cmd_pkg::resume_alt2_cmd};
      foreach (otp[k]) otp[k] = flash_cmd_pkg::BYTE_ERASED;
      foreach (wd[k]) wd[k] = 8'h00;
      repeat (3) @(negedge i_clk_sys);
      i_rst_n = 1'b1;
      chk(o_protect_config, flash_cmd_pkg::PROTECT_CONFIG_RESET);
      chk({15'h0, o_write_enabled}, 16'h0);
      chk({15'h0, |o_sector_locks}, 16'h0);
      // Each suspend and resume code
      for (i = 0; i < 6; i++) begin
         s0 = n_susp;
         r0 = n_res;
         run(ops[i], 32'h0, 3'h0, 8'h00);
         chk(16'(n_susp - s0), (i < 3) ? 16'h1 : 16'h0);
         chk(16'(n_res - r0), (i < 3) ? 16'h0 : 16'h1);
         if (i < 3) chk({15'h0, o_suspend_all}, (i == 0) ? 16'h1 : 16'h0);
      end
      // A trailing byte makes the suspend frame void
      s0 = n_susp;
      run(flash_cmd_pkg::suspend_all_ops_cmd, 32'h0, 3'h0, 8'h01);
      chk(16'(n_susp - s0), 16'h0);
      // Config word refused without write enable, then taken low byte first
      wd[0] = 8'h34;
      wd[1] = 8'h12;
      run(flash_cmd_pkg::protect_config_write_cmd, 32'h0, 3'h0, 8'h02);
      chk(o_protect_config, flash_cmd_pkg::PROTECT_CONFIG_RESET);
      run(flash_cmd_pkg::write_enable_cmd, 32'h0, 3'h0, 8'h00);
      chk({15'h0, o_write_enabled}, 16'h1);
      run(flash_cmd_pkg::protect_config_write_cmd, 32'h0, 3'h0, 8'h02);
      chk(o_protect_config, 16'h1234);
      chk({15'h0, o_write_enabled}, 16'h0);
      // Volatile locks: short, wide; lock, unlock
      for (i = 0; i < 2; i++) begin
         a = $random(seed);
         if (i == 0) a[31:24] = 8'h00;
         al = (i == 0) ? 3'h3 : 3'h4;
         for (j = 0; j < 2; j++) begin
            wd[0] = (j == 0) ? 8'hff : (8'($random(seed)) & 8'hfe);
            run(flash_cmd_pkg::write_enable_cmd, 32'h0, 3'h0, 8'h00);
            run((i == 0) ? flash_cmd_pkg::volatile_lock_write_cmd :
               flash_cmd_pkg::volatile_lock_write_wide_cmd, a, al, 8'h01);
            chk({15'h0, o_sector_locks[a[25:18]]}, (j == 0) ? 16'h1 : 16'h0);
            run((i == 0) ? flash_cmd_pkg::volatile_lock_read_cmd :
               flash_cmd_pkg::volatile_lock_read_wide_cmd, a, al, 8'h02);
            for (int k = 0; k < 2; k++) chk({8'h00, rd[k]}, {8'h00, lock_byte(j == 0)});
         end
      end
      wd[0] = 8'hff;
      run(flash_cmd_pkg::volatile_lock_write_wide_cmd, a, 3'h4, 8'h01);
      chk({15'h0, o_sector_locks[a[25:18]]}, 16'h0);
      // OTP program and read back; second pass wraps the end
      for (i = 0; i < 2; i++) begin
         i_addr4 = (i == 1);
         a = (i == 0) ? {24'h0, 8'($random(seed))} : 32'h3ff;
         al = (i == 0) ? 3'h3 : 3'h4;
         wd[0] = 8'($random(seed));
         wd[1] = 8'($random(seed));
         run(flash_cmd_pkg::write_enable_cmd, 32'h0, 3'h0, 8'h00);
         run(flash_cmd_pkg::otp_program_cmd, a, al, 8'h02);
         otp[a[9:0]] = otp[a[9:0]] & wd[0];
         otp[a[9:0] + 10'h001] = otp[a[9:0] + 10'h001] & wd[1];
         rd_otp(al);
      end
      wd[0] = 8'h00;
      run(flash_cmd_pkg::otp_program_cmd, a, 3'h4, 8'h01);
      rd_otp(3'h4);
      finish_test();
   end
endmodule
